// >>> rtl/corr_job_cfg.svh
// Offsets, field positions, reset values and counts of the correlator job decoder
`ifndef CORR_JOB_CFG_SVH
`define CORR_JOB_CFG_SVH
// ***
// Register byte offsets
// ***
`define CJ_OFS_CTRL        8'h00
`define CJ_OFS_JOB         8'h04
`define CJ_OFS_BUF_SIZE    8'h08
`define CJ_OFS_FETCH_OFS   8'h0C
`define CJ_OFS_BASE0       8'h10
`define CJ_OFS_BASE1       8'h14
`define CJ_OFS_COMBINE     8'h18
`define CJ_OFS_FC_START    8'h1C
`define CJ_OFS_FC_INCR     8'h20
`define CJ_OFS_OUT_BASE    8'h24
`define CJ_OFS_ACC_BASE    8'h28
`define CJ_OFS_SIZES       8'h2C
`define CJ_OFS_STEER       8'h30
`define CJ_OFS_GO          8'h34
`define CJ_OFS_ACTIVATE    8'h38
`define CJ_OFS_STATUS      8'h3C
`define CJ_OFS_IRQ_STATUS  8'h40
`define CJ_OFS_IRQ_CLEAR   8'h44
`define CJ_OFS_IRQ_ENABLE  8'h48
`define CJ_TABLE_BIT       7
// ***
// Job word fields
// ***
`define CJ_JOB_PRIO_LSB              0
`define CJ_JOB_USERS_LSB             2
`define CJ_JOB_FETCH_LSB             10
`define CJ_HOLD_UNTIL_TRIGGERED_BIT  31
`define CJ_END_OF_JOB_IRQ_BIT        28
// ***
// User entry fields (low word, high word)
// ***
`define CJ_ENT_PILOT_LSB   0
`define CJ_ENT_MODE_BIT    4
`define CJ_ENT_FC_ON_BIT   5
`define CJ_ENT_LAST_BIT    6
`define CJ_ENT_SST_BIT     7
`define CJ_ENT_MASK_LSB    0
`define CJ_ENT_QUAD_BIT    15
`define CJ_ENT_STEP_LSB    16
`define CJ_ENT_SSO_BIT     24
// ***
// Counts and reset values
// ***
`define CJ_SUBSLOTS        10
`define CJ_SUBSLOT_SHIFT   8
`define CJ_STEP_UNIT_SHIFT 4
`define CJ_SSO_OFFSET      13'h1000
`define CJ_IRQ_DONE_BIT    0
`define CJ_IRQ_SEQ_BIT     1
`define CJ_RST_WORD        32'h0000_0000
`endif

// >>> rtl/corr_job_pkg.sv
// Types shared by the correlator job decoder
package corr_job_pkg;
   // Job sequencer states, Gray along the usual path
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_HOLD    = 3'h1,
      ST_FETCH0  = 3'h3,
      ST_FETCH1  = 3'h2,
      ST_RDREQ   = 3'h6,
      ST_RDWAIT  = 3'h7,
      ST_PRESENT = 3'h5,
      ST_DONE    = 3'h4
   } job_state_e;
endpackage

// >>> rtl/user_entry_table.sv
// User entry table: two 32-bit halves per entry, registered read
`timescale 1ns/1ps
module user_entry_table #(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic          i_clk,
   input  wire logic [1:0]    i_wr_en,
   input  wire logic [AW-1:0] i_wr_addr,
   input  wire logic [31:0]   i_wr_data,
   input  wire logic          i_rd_en,
   input  wire logic [AW-1:0] i_rd_addr,
   output logic      [63:0]   o_rd_data
);
   logic [31:0] lo_mem [DEPTH];
   logic [31:0] hi_mem [DEPTH];

   // Half-word writes, whole-entry registered read
   always_ff @(posedge i_clk) begin
      if (i_wr_en[0]) begin
         lo_mem[i_wr_addr] <= i_wr_data;
      end
      if (i_wr_en[1]) begin
         hi_mem[i_wr_addr] <= i_wr_data;
      end
      if (i_rd_en) begin
         o_rd_data <= {hi_mem[i_rd_addr], lo_mem[i_rd_addr]};
      end
   end
endmodule

// >>> rtl/corr_job_decode.sv
// Correlator job descriptor and user entry decoder with AHB-Lite registers
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "corr_job_cfg.svh"
// Function
// - Mode bit 0 selects path-search, 1 selects random-access preamble.
// - External-pilot mask bit x covers chips x*256 to (x+1)*256-1, x 0..9.
// - Mask honoured only in path-search with pilot count zero.
// - Pilot field bit 0x8000 maps external pilots to quadrature, else in-phase.
// - Hold flag 0x80000000 keeps job waiting for explicit activation command.
// - Flag 0x10000000 raises an interrupt when the job completes.
// - Step size field counts 16-sample units, encoded as samples/16 minus one.
// - Frequency correction applied with start and step values only when enabled.
// - Each diversity buffer fetches the 11-bit count of 32-byte chunks.
// - Job searches up to the number of users given by the 8-bit count, stopping after an entry with the last flag set.
// - Offset selector 0 adds nothing, selector 1 adds 4096.
// - Two diversity buffers with own bases share size and fetch offset.
// - Per user, output and accumulator buffers with address, size, steering bits.
// - Sub-slot code: 0 skip, 1 coherent, 3 unweighted move, 4-7 weights 0-3.
// - Memory accesses carry the job priority when priority scheduling is on.
module corr_job_decode #(
   parameter int TABLE_DEPTH = 16
) (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic      [31:0] o_hrdata,
   output logic             o_fetch_valid,
   input  wire logic        i_fetch_ready,
   output logic             o_fetch_buf_sel,
   output logic      [31:0] o_fetch_addr,
   output logic      [31:0] o_fetch_buf_size,
   output logic      [10:0] o_fetch_chunks,
   output logic      [1:0]  o_bus_prio,
   output logic             o_user_valid,
   input  wire logic        i_user_ready,
   output logic      [7:0]  o_user_index,
   output logic             o_preamble_mode,
   output logic      [3:0]  o_pilot_count,
   output logic      [3:0]  o_signature,
   output logic             o_ext_pilot_en,
   output logic      [9:0]  o_external_pilot_mask,
   output logic             o_pilot_quadrature_select,
   output logic             o_freq_correction_on,
   output logic      [31:0] o_fc_start,
   output logic      [31:0] o_fc_incr,
   output logic      [12:0] o_fc_step_samples,
   output logic             o_scr_long,
   output logic      [12:0] o_scr_offset,
   output logic      [31:0] o_out_addr,
   output logic      [15:0] o_out_size,
   output logic      [3:0]  o_out_steer,
   output logic      [31:0] o_acc_addr,
   output logic      [15:0] o_acc_size,
   output logic      [3:0]  o_acc_steer,
   output logic      [9:0]  o_slot_coherent,
   output logic      [9:0]  o_slot_nc_move,
   output logic      [9:0]  o_slot_weighted,
   output logic      [19:0] o_slot_weight_sel,
   input  wire logic [11:0] i_chip_index,
   output logic             o_chip_pilot,
   output logic             o_chip_pilot_valid,
   output logic             o_busy,
   output logic             o_irq
);
   typedef struct packed {
      corr_job_pkg::job_state_e state;
      logic        prio_en;
      logic [31:0] job;
      logic [31:0] buf_size;
      logic [31:0] fetch_ofs;
      logic [31:0] base0;
      logic [31:0] base1;
      logic [29:0] combine;
      logic [31:0] fc_start;
      logic [31:0] fc_incr;
      logic [31:0] out_base;
      logic [31:0] acc_base;
      logic [31:0] sizes;
      logic [7:0]  steer;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_en;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] hrdata;
      logic [7:0]  idx;
      logic        last_seen;
      logic        preamble;
      logic [3:0]  pilot_cnt;
      logic [3:0]  signature;
      logic        ext_en;
      logic [9:0]  mask;
      logic        quad;
      logic        fc_on;
      logic [31:0] fc_start_o;
      logic [31:0] fc_incr_o;
      logic [12:0] fc_samples;
      logic        scr_long;
      logic [12:0] scr_ofs;
      logic [31:0] out_addr;
      logic [31:0] acc_addr;
      logic [9:0]  coh;
      logic [9:0]  ncm;
      logic [9:0]  wtd;
      logic [19:0] wsel;
      logic        chip_pilot;
      logic        chip_valid;
   } state_s;

   state_s      st;
   state_s      next_st;
   logic [1:0]  tbl_we;
   logic        tbl_re;
   logic [63:0] entry;
   logic [7:0]  users;
   logic [1:0]  irq_set;
   logic [1:0]  irq_clr;
   logic        go_wr;
   logic        act_wr;
   logic [3:0]  sub;
   logic [2:0]  code;

   // ********************************************************
   // User entry table
   // ********************************************************
   user_entry_table #(.DEPTH(TABLE_DEPTH), .AW(4)) u_table (
      .i_clk     (i_clk),
      .i_wr_en   (tbl_we),
      .i_wr_addr (st.wr_addr[6:3]),
      .i_wr_data (i_hwdata),
      .i_rd_en   (tbl_re),
      .i_rd_addr (st.idx[3:0]),
      .o_rd_data (entry)
   );

   // ********************************************************
   // Next-state logic
   // ********************************************************
   always_comb begin
      next_st = st;
      users   = st.job[`CJ_JOB_USERS_LSB +: 8];
      tbl_we  = 2'h0;
      tbl_re  = 1'b0;
      irq_set = 2'h0;
      irq_clr = 2'h0;
      go_wr   = 1'b0;
      act_wr  = 1'b0;
      sub     = i_chip_index[11:`CJ_SUBSLOT_SHIFT];
      code    = 3'h0;
      // Data phase of a write: update the addressed register
      if (st.wr_pend) begin
         if (st.wr_addr[`CJ_TABLE_BIT]) begin
            tbl_we = st.wr_addr[2] ? 2'h2 : 2'h1;
         end else begin
            unique case (st.wr_addr)
               `CJ_OFS_CTRL:       next_st.prio_en = i_hwdata[0];
               `CJ_OFS_JOB:        next_st.job = i_hwdata;
               `CJ_OFS_BUF_SIZE:   next_st.buf_size = i_hwdata;
               `CJ_OFS_FETCH_OFS:  next_st.fetch_ofs = i_hwdata;
               `CJ_OFS_BASE0:      next_st.base0 = i_hwdata;
               `CJ_OFS_BASE1:      next_st.base1 = i_hwdata;
               `CJ_OFS_COMBINE:    next_st.combine = i_hwdata[29:0];
               `CJ_OFS_FC_START:   next_st.fc_start = i_hwdata;
               `CJ_OFS_FC_INCR:    next_st.fc_incr = i_hwdata;
               `CJ_OFS_OUT_BASE:   next_st.out_base = i_hwdata;
               `CJ_OFS_ACC_BASE:   next_st.acc_base = i_hwdata;
               `CJ_OFS_SIZES:      next_st.sizes = i_hwdata;
               `CJ_OFS_STEER:      next_st.steer = i_hwdata[7:0];
               `CJ_OFS_GO:         go_wr = i_hwdata[0];
               `CJ_OFS_ACTIVATE:   act_wr = i_hwdata[0];
               `CJ_OFS_IRQ_CLEAR:  irq_clr = i_hwdata[1:0];
               `CJ_OFS_IRQ_ENABLE: next_st.irq_en = i_hwdata[1:0];
               default:            next_st.wr_pend = 1'b0;
            endcase
         end
      end
      // Address phase: capture writes, register read data
      next_st.wr_pend = i_hsel & i_htrans[1] & i_hready & i_hwrite;
      if (i_hsel & i_htrans[1] & i_hready) begin
         next_st.wr_addr = i_haddr[7:0];
         unique case (i_haddr[7:0])
            `CJ_OFS_CTRL:       next_st.hrdata = {31'h0, st.prio_en};
            `CJ_OFS_JOB:        next_st.hrdata = st.job;
            `CJ_OFS_BUF_SIZE:   next_st.hrdata = st.buf_size;
            `CJ_OFS_FETCH_OFS:  next_st.hrdata = st.fetch_ofs;
            `CJ_OFS_BASE0:      next_st.hrdata = st.base0;
            `CJ_OFS_BASE1:      next_st.hrdata = st.base1;
            `CJ_OFS_COMBINE:    next_st.hrdata = {2'h0, st.combine};
            `CJ_OFS_FC_START:   next_st.hrdata = st.fc_start;
            `CJ_OFS_FC_INCR:    next_st.hrdata = st.fc_incr;
            `CJ_OFS_OUT_BASE:   next_st.hrdata = st.out_base;
            `CJ_OFS_ACC_BASE:   next_st.hrdata = st.acc_base;
            `CJ_OFS_SIZES:      next_st.hrdata = st.sizes;
            `CJ_OFS_STEER:      next_st.hrdata = {24'h0, st.steer};
            `CJ_OFS_STATUS:     next_st.hrdata = {20'h0, st.idx, st.state, o_busy};
            `CJ_OFS_IRQ_STATUS: next_st.hrdata = {30'h0, st.irq_stat};
            `CJ_OFS_IRQ_ENABLE: next_st.hrdata = {30'h0, st.irq_en};
            default:            next_st.hrdata = `CJ_RST_WORD;
         endcase
      end
      // Job sequencer
      unique case (st.state)
         corr_job_pkg::ST_IDLE: begin
            if (go_wr) begin
               next_st.idx = 8'h00;
               next_st.last_seen = 1'b0;
               next_st.state = st.job[`CJ_HOLD_UNTIL_TRIGGERED_BIT] ?
                               corr_job_pkg::ST_HOLD : corr_job_pkg::ST_FETCH0;
            end
         end
         corr_job_pkg::ST_HOLD: begin
            if (act_wr) begin
               next_st.state = corr_job_pkg::ST_FETCH0;
            end
         end
         corr_job_pkg::ST_FETCH0: begin
            if (i_fetch_ready) begin
               next_st.state = corr_job_pkg::ST_FETCH1;
            end
         end
         corr_job_pkg::ST_FETCH1: begin
            if (i_fetch_ready) begin
               next_st.state = (users == 8'h00) ? corr_job_pkg::ST_DONE : corr_job_pkg::ST_RDREQ;
            end
         end
         corr_job_pkg::ST_RDREQ: begin
            tbl_re = 1'b1;
            next_st.state = corr_job_pkg::ST_RDWAIT;
         end
         corr_job_pkg::ST_RDWAIT: begin
            // Decode the fetched entry into registered outputs
            next_st.preamble   = entry[`CJ_ENT_MODE_BIT];
            next_st.pilot_cnt  = entry[`CJ_ENT_MODE_BIT] ? 4'h0 : entry[`CJ_ENT_PILOT_LSB +: 4];
            next_st.signature  = entry[`CJ_ENT_MODE_BIT] ? entry[`CJ_ENT_PILOT_LSB +: 4] : 4'h0;
            next_st.ext_en     = ~entry[`CJ_ENT_MODE_BIT] & (entry[`CJ_ENT_PILOT_LSB +: 4] == 4'h0);
            next_st.mask       = next_st.ext_en ? entry[32 + `CJ_ENT_MASK_LSB +: `CJ_SUBSLOTS] : 10'h000;
            next_st.quad       = entry[32 + `CJ_ENT_QUAD_BIT];
            next_st.fc_on      = entry[`CJ_ENT_FC_ON_BIT];
            next_st.fc_start_o = entry[`CJ_ENT_FC_ON_BIT] ? st.fc_start : `CJ_RST_WORD;
            next_st.fc_incr_o  = entry[`CJ_ENT_FC_ON_BIT] ? st.fc_incr : `CJ_RST_WORD;
            next_st.fc_samples = (13'(entry[32 + `CJ_ENT_STEP_LSB +: 8]) + 13'h001) << `CJ_STEP_UNIT_SHIFT;
            next_st.scr_long   = entry[`CJ_ENT_SST_BIT];
            next_st.scr_ofs    = entry[32 + `CJ_ENT_SSO_BIT] ? `CJ_SSO_OFFSET : 13'h0000;
            next_st.last_seen  = entry[`CJ_ENT_LAST_BIT];
            next_st.out_addr   = st.out_base + 32'(st.idx) * 32'(st.sizes[15:0]);
            next_st.acc_addr   = st.acc_base + 32'(st.idx) * 32'(st.sizes[31:16]);
            // Random-access entry with short sequence is flagged to software
            irq_set[`CJ_IRQ_SEQ_BIT] = entry[`CJ_ENT_MODE_BIT] & ~entry[`CJ_ENT_SST_BIT];
            // Per sub-slot combining decode
            for (int s = 0; s < `CJ_SUBSLOTS; s++) begin
               code = st.combine[3*s +: 3];
               next_st.coh[s] = (code == 3'h1);
               next_st.ncm[s] = (code == 3'h3) | code[2];
               next_st.wtd[s] = code[2];
               next_st.wsel[2*s +: 2] = code[2] ? code[1:0] : 2'h0;
            end
            next_st.state = corr_job_pkg::ST_PRESENT;
         end
         corr_job_pkg::ST_PRESENT: begin
            if (i_user_ready) begin
               if (st.last_seen | (st.idx + 8'h01 == users)) begin
                  next_st.state = corr_job_pkg::ST_DONE;
               end else begin
                  next_st.idx = st.idx + 8'h01;
                  next_st.state = corr_job_pkg::ST_RDREQ;
               end
            end
         end
         corr_job_pkg::ST_DONE: begin
            irq_set[`CJ_IRQ_DONE_BIT] = st.job[`CJ_END_OF_JOB_IRQ_BIT];
            next_st.state = corr_job_pkg::ST_IDLE;
         end
      endcase
      // Sticky interrupt bits, set wins over clear
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
      // Chip-indexed external pilot lookup
      next_st.chip_valid = st.ext_en & (sub < 4'(`CJ_SUBSLOTS));
      next_st.chip_pilot = next_st.chip_valid & st.mask[sub];
   end

   // ********************************************************
   // State register
   // ********************************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ********************************************************
   // Outputs
   // ********************************************************
   assign o_hreadyout               = 1'b1;
   assign o_hresp                   = 1'b0;
   assign o_hrdata                  = st.hrdata;
   assign o_busy                    = (st.state != corr_job_pkg::ST_IDLE);
   assign o_irq                     = |(st.irq_stat & st.irq_en);
   // Fetch requests, first then second diversity buffer
   assign o_fetch_valid             = (st.state == corr_job_pkg::ST_FETCH0) |
                                      (st.state == corr_job_pkg::ST_FETCH1);
   assign o_fetch_buf_sel           = (st.state == corr_job_pkg::ST_FETCH1);
   assign o_fetch_addr              = (o_fetch_buf_sel ? st.base1 : st.base0) + st.fetch_ofs;
   assign o_fetch_buf_size          = st.buf_size;
   assign o_fetch_chunks            = st.job[`CJ_JOB_FETCH_LSB +: 11];
   assign o_bus_prio                = st.prio_en ? st.job[`CJ_JOB_PRIO_LSB +: 2] : 2'h0;
   assign o_user_valid              = (st.state == corr_job_pkg::ST_PRESENT);
   assign o_user_index              = st.idx;
   assign o_preamble_mode           = st.preamble;
   assign o_pilot_count             = st.pilot_cnt;
   assign o_signature               = st.signature;
   assign o_ext_pilot_en            = st.ext_en;
   assign o_external_pilot_mask     = st.mask;
   assign o_pilot_quadrature_select = st.quad;
   assign o_freq_correction_on      = st.fc_on;
   assign o_fc_start                = st.fc_start_o;
   assign o_fc_incr                 = st.fc_incr_o;
   assign o_fc_step_samples         = st.fc_samples;
   assign o_scr_long                = st.scr_long;
   assign o_scr_offset              = st.scr_ofs;
   assign o_out_addr                = st.out_addr;
   assign o_out_size                = st.sizes[15:0];
   assign o_out_steer               = st.steer[3:0];
   assign o_acc_addr                = st.acc_addr;
   assign o_acc_size                = st.sizes[31:16];
   assign o_acc_steer               = st.steer[7:4];
   assign o_slot_coherent           = st.coh;
   assign o_slot_nc_move            = st.ncm;
   assign o_slot_weighted           = st.wtd;
   assign o_slot_weight_sel         = st.wsel;
   assign o_chip_pilot              = st.chip_pilot;
   assign o_chip_pilot_valid        = st.chip_valid;
endmodule

// >>> tb/corr_job_monitor.sv
// Port checker of the correlator job decoder
`timescale 1ns/1ps
module corr_job_monitor (
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   input wire logic        o_fetch_valid,
   input wire logic        i_fetch_ready,
   input wire logic        o_fetch_buf_sel,
   input wire logic        o_user_valid,
   input wire logic        i_user_ready,
   input wire logic [7:0]  o_user_index,
   input wire logic        o_preamble_mode,
   input wire logic [3:0]  o_pilot_count,
   input wire logic        o_ext_pilot_en,
   input wire logic [9:0]  o_external_pilot_mask,
   input wire logic [12:0] o_fc_step_samples,
   input wire logic [12:0] o_scr_offset,
   input wire logic [11:0] i_chip_index,
   input wire logic        o_chip_pilot,
   input wire logic        o_chip_pilot_valid
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ***
   // Handshake steps
   // ***
   sequence fetch_wait; o_fetch_valid && !i_fetch_ready; endsequence
   sequence buf0_taken; o_fetch_valid && i_fetch_ready && !o_fetch_buf_sel; endsequence
   sequence buf1_taken; o_fetch_valid && i_fetch_ready && o_fetch_buf_sel; endsequence
   sequence user_wait; o_user_valid && !i_user_ready; endsequence
   fetch_hold_a: assert property (fetch_wait |=> o_fetch_valid && $stable(o_fetch_buf_sel))
      else $error("fetch request dropped");
   buf_order_a: assert property (buf0_taken |=> o_fetch_valid && o_fetch_buf_sel)
      else $error("second buffer not next");
   fetch_end_a: assert property (buf1_taken |=> !o_fetch_valid [*2])
      else $error("extra fetch request");
   user_hold_a: assert property (user_wait |=> o_user_valid && $stable(o_user_index))
      else $error("user entry dropped");
   mode_mask_a: assert property (o_user_valid |-> o_ext_pilot_en == (!o_preamble_mode && o_pilot_count == 4'h0))
      else $error("pilot mask enable wrong");
   mask_off_a: assert property (o_user_valid && !o_ext_pilot_en |-> o_external_pilot_mask == 10'h000)
      else $error("ignored mask not cleared");
   step_unit_a: assert property (o_user_valid |-> o_fc_step_samples[3:0] == 4'h0 && o_fc_step_samples != 13'h0000)
      else $error("step length not in units of 16");
   sso_pick_a: assert property (o_user_valid |-> o_scr_offset inside {13'h0000, 13'h1000})
      else $error("scrambling offset wrong");
   chip_range_a: assert property (o_user_valid && $past(o_user_valid) |->
      o_chip_pilot_valid == ($past(o_ext_pilot_en) && $past(i_chip_index[11:8]) < 4'hA))
      else $error("chip pilot validity wrong");
   chip_bit_a: assert property (o_chip_pilot_valid |->
      o_chip_pilot == |(10'h001 & ($past(o_external_pilot_mask) >> $past(i_chip_index[11:8]))))
      else $error("chip pilot bit wrong");
endmodule
bind corr_job_decode corr_job_monitor corr_job_monitor_inst (.*);

// >>> tb/corr_far_side.sv
// Far-side model answering fetch and user handshakes after a set delay
`timescale 1ns/1ps
module corr_far_side (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [3:0]  i_delay,
   input  wire logic        i_fetch_valid,
   input  wire logic        i_user_valid,
   output logic             o_fetch_ready,
   output logic             o_user_ready,
   output logic      [11:0] o_chip_index
);
   logic [3:0] wait_cnt;
   // Chip index sweeps all sub-slots; ready follows a standing request
   always_ff @(posedge i_clk) begin
      o_chip_index <= i_sys_rst ? 12'h000 : o_chip_index + 12'h040;
      if (i_sys_rst || o_fetch_ready || o_user_ready) begin
         wait_cnt      <= 4'h0;
         o_fetch_ready <= 1'b0;
         o_user_ready  <= 1'b0;
      end else if (wait_cnt < i_delay) begin
         wait_cnt <= wait_cnt + {3'h0, i_fetch_valid || i_user_valid};
      end else begin
         o_fetch_ready <= i_fetch_valid;
         o_user_ready  <= i_user_valid;
      end
   end
endmodule

// >>> tb/tb_corr_job_decode.sv
// Testbench of the correlator job decoder
`timescale 1ns/1ps
module tb_corr_job_decode;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        i_hwrite = 1'b0;
   logic [1:0]  i_htrans = 2'h0;
   logic [31:0] i_haddr = 32'h0000_0000;
   logic [31:0] i_hwdata = 32'h0000_0000;
   logic [3:0]  delay = 4'h7;
   logic [11:0] i_chip_index;
   logic        i_fetch_ready, i_user_ready, o_hreadyout, o_hresp, o_fetch_valid, o_fetch_buf_sel, o_user_valid;
   logic        o_preamble_mode, o_ext_pilot_en, o_pilot_quadrature_select, o_freq_correction_on, o_scr_long;
   logic        o_chip_pilot, o_chip_pilot_valid, o_busy, o_irq;
   logic [31:0] o_hrdata, o_fetch_addr, o_fetch_buf_size, o_fc_start, o_fc_incr, o_out_addr, o_acc_addr, q;
   logic [12:0] o_fc_step_samples, o_scr_offset;
   logic [10:0] o_fetch_chunks;
   logic [1:0]  o_bus_prio;
   logic [7:0]  o_user_index;
   logic [3:0]  o_pilot_count, o_signature, o_out_steer, o_acc_steer;
   logic [9:0]  o_external_pilot_mask, o_slot_coherent, o_slot_nc_move, o_slot_weighted;
   logic [15:0] o_out_size, o_acc_size;
   logic [19:0] o_slot_weight_sel;
   int          fail_count = 0;
   int          n_compared = 0;
   int          users_taken = 0;
   logic [7:0]  cfg_a [18] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C,
                               8'h30, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h48, 8'h04};
   logic [31:0] cfg_d [18] = '{32'h1, 32'h8000, 32'h200, 32'h4000_0000, 32'h5000_0000, 32'h01FA_C688,
                               32'h1234_5678, 32'h0ABC_0DEF, 32'h1000_0000, 32'h2000_0000, 32'h0040_0100, 32'hA5,
                               32'h20, 32'h0103_82A5, 32'hD9, 32'h3FF, 32'h1, 32'h101F_FC0E};
   corr_job_decode corr_job_decode_inst (.*, .i_hsel(1'b1), .i_hsize(3'h2), .i_hready(o_hreadyout));
   corr_far_side corr_far_side_inst (.i_clk, .i_sys_rst, .i_delay(delay), .i_fetch_valid(o_fetch_valid),
      .i_user_valid(o_user_valid), .o_fetch_ready(i_fetch_ready), .o_user_ready(i_user_ready),
      .o_chip_index(i_chip_index));
   // ***
   // Clock, counters and access tasks
   // ***
   initial forever #5 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_user_valid && i_user_ready) users_taken++;
   task automatic conclude;
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Edge at which: 0 bus ready, 1 fetch taken, 2 user taken, 3 idle
   task automatic step_until(input int which);
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (!(which == 0 ? o_hreadyout === 1'b1 : which == 1 ? (o_fetch_valid && i_fetch_ready) === 1'b1 :
                   which == 2 ? (o_user_valid && i_user_ready) === 1'b1 : o_busy === 1'b0) && n < 300);
      if (n >= 300) begin
         fail_count++;
         $display("[ERR] %0t wait ran out", $time);
         conclude();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      i_htrans <= 2'h2;
      i_haddr  <= {24'h00_0000, a};
      i_hwrite <= wr;
      step_until(0);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      step_until(0);
      q = o_hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // User entry fields, step and offset, increment, output and accumulator addresses
   task automatic user_chk(input logic [31:0] f, input logic [31:0] s, input logic [31:0] c, input logic [31:0] o,
                           input logic [31:0] k);
      step_until(2);
      chk({o_user_index, o_pilot_count, o_signature, o_external_pilot_mask, o_preamble_mode, o_ext_pilot_en,
           o_pilot_quadrature_select, o_freq_correction_on, o_scr_long, 1'b0}, f);
      chk({6'h0, o_fc_step_samples, o_scr_offset}, s);
      chk(o_fc_incr, c);
      chk(o_out_addr, o);
      chk(o_acc_addr, k);
   endtask
   // ***
   // Main sequence
   // ***
   initial begin
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      rd(8'h04, 32'h0);
      rd(8'h4C, 32'h0);
      foreach (cfg_a[i]) ahb(1'b1, cfg_a[i], cfg_d[i]);
      rd(8'h04, 32'h101F_FC0E);
      rd(8'h80, 32'h0);
      ahb(1'b1, 8'h34, 32'h1);
      step_until(1);
      chk(o_fetch_addr, 32'h4000_0200);
      chk({19'h0, o_bus_prio, o_fetch_chunks}, {19'h0, 2'h2, 11'h7FF});
      chk(o_fetch_buf_size, 32'h8000);
      step_until(1);
      chk(o_fetch_addr, 32'h5000_0200);
      user_chk({8'h00, 8'h00, 10'h2A5, 6'b011100}, {6'h0, 13'h40, 13'h1000}, 32'h0ABC_0DEF, 32'h1000_0000,
               32'h2000_0000);
      chk(o_fc_start, 32'h1234_5678);
      chk({2'h0, o_slot_coherent, o_slot_nc_move, o_slot_weighted}, {2'h0, 10'h102, 10'h0F8, 10'h0F0});
      chk({12'h0, o_slot_weight_sel}, 32'h0000_E400);
      chk({23'h0, o_hresp, o_acc_steer, o_out_steer}, 32'hA5);
      chk({o_acc_size, o_out_size}, 32'h0040_0100);
      user_chk({8'h01, 8'h09, 10'h000, 6'b100010}, {6'h0, 13'h10, 13'h0}, 32'h0, 32'h1000_0100,
               32'h2000_0040);
      step_until(3);
      chk(users_taken, 32'd2);
      chk({31'h0, o_irq}, 32'h1);
      ahb(1'b1, 8'h48, 32'h0);
      rd(8'h40, 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      ahb(1'b1, 8'h44, 32'h1);
      ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
      ahb(1'b1, 8'h48, 32'h3);
      rd(8'h40, 32'h0);
      chk({31'h0, o_irq}, 32'h0);
      delay <= 4'h0;
      ahb(1'b1, 8'h80, 32'h50);
      ahb(1'b1, 8'h04, 32'h8000_0004);
      ahb(1'b1, 8'h34, 32'h1);
      repeat (8) @(posedge i_clk);
      chk({30'h0, o_busy, o_fetch_valid}, 32'h2);
      ahb(1'b1, 8'h38, 32'h1);
      step_until(1);
      step_until(1);
      user_chk({8'h00, 8'h00, 10'h000, 6'b101000}, {6'h0, 13'h40, 13'h1000}, 32'h0, 32'h1000_0000,
               32'h2000_0000);
      step_until(3);
      rd(8'h40, 32'h2);
      chk({31'h0, o_irq}, 32'h1);
      chk(users_taken, 32'd3);
      conclude();
   end
endmodule
